//--- include/aux_ctl_pkg.sv
// What the document requires of source and sink
// R01: Source is sole requester; sink only replies to requests.
// R02: Hot plug detection moves the source controller into idle.
// R03: Sink is idle whenever it drives hot plug detect asserted.
// R04: Source-monitoring sink waits in source-wait state until source detected.
// R05: Source idle is talk mode; sink idle is listen mode.
// R06: After sending a request source goes pending, listens, issues nothing new.
// R07: Sink receiving a request goes reply pending and talks.
// R08: Sink replies within 300 us or silently returns idle.
// R09: Source reply timer of 400 us starts on pending; timeout returns idle.
// R10: Connector power may be off only in reset; on in other states.
// R11: Unplugged to idle on detect; back to unplugged on loss; reset anytime.
// R12: Sink off drops detect; source-wait powers on, detect low.
// R13: Sink idle and pending assert detect and power; loss goes source-wait.
// R14: Sink stays idle when source writes 2 to location 600h.
// R15: Power-saving sink replies within 1 ms of channel activity.
// R16: Never both talking or listening; sink timeout shorter; timeout goes idle.
// R17: No nested transactions: reply or timeout before next request.
// R18: Requests start only on policy submission, in submission order; automatic retries after a reply timeout start without one.
// R19: NACK and DEFER outcomes pass up to the policy maker.
// R20: At most 16 data bytes per transaction.
// R21: No transaction occupies the channel beyond 500 us at 1 Mbit/s; this block times only the request phase against 500 us.
// R22: Reset state while reset asserted; unplugged after release.
// R23: On entering unplugged, report hot plug level upward.
// R24: Retry at least three times after a reply timeout.
// R25: Report each outcome as one-cycle event; accept requests only in idle.
//
// Purpose: constants for the auxiliary channel source link controller
// Assumes: 40 MHz system clock
// Notes:   times are kept in their own unit and converted to cycles here
package aux_ctl_pkg;
  localparam int CLK_MHZ          = 40;
  localparam int REPLY_WAIT_US    = 400;
  localparam int MAX_TXN_US       = 500;
  localparam int REPLY_WAIT_CYC   = REPLY_WAIT_US * CLK_MHZ;
  localparam int MAX_TXN_CYC      = MAX_TXN_US * CLK_MHZ;
  localparam int TMR_W            = 15;
  localparam int MAX_BYTES        = 16;
  localparam int LEN_W            = 5;
  localparam int MIN_RETRIES      = 3;
  localparam int MAX_TIMEOUTS     = MIN_RETRIES + 1;
  localparam int RETRY_W          = 3;

  typedef enum logic [1:0] {
    OUT_ACK,
    OUT_NACK,
    OUT_DEFER,
    OUT_TIMEOUT
  } outcome_t;

  typedef enum logic [1:0] {
    REPLY_ACK,
    REPLY_NACK,
    REPLY_DEFER,
    REPLY_OTHER
  } reply_code_t;

  typedef enum logic [1:0] {
    source_reset_state,
    source_unplugged_state,
    source_idle_state,
    source_request_pending_state
  } src_state_t;
endpackage

//--- verilog/aux_wait_timer.sv
// Purpose: loadable down-counter flagging expiry of a wait window
// Assumes: start has priority over counting
// Notes:   expired pulses one cycle, one edge after count reaches one
`timescale 1ns/1ps
module aux_wait_timer
  import aux_ctl_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  input  wire logic             start_in,
  input  wire logic             stop_in,
  input  wire logic [TMR_W-1:0] load_in,
  output logic                  expired_out
);
  typedef struct packed {
    logic [TMR_W-1:0] count;
    logic             run;
    logic             expired;
  } tmr_t;

  tmr_t r;
  tmr_t next_r;

  always_comb begin
    next_r = r;
    next_r.expired = 1'b0;
    if (start_in) begin
      next_r.count = load_in;
      next_r.run   = 1'b1;
    end else if (stop_in) begin
      next_r.run = 1'b0;
    end else if (r.run) begin
      if (r.count == TMR_W'(1)) begin
        next_r.expired = 1'b1;
        next_r.run     = 1'b0;
      end
      next_r.count = r.count - TMR_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign expired_out = r.expired;
endmodule

//--- verilog/aux_retry_count.sv
// Purpose: counts consecutive reply timeouts of one submitted request
// Assumes: clear on any reply or new submission
// Notes:   saturates so a dead sink cannot wrap the count
`timescale 1ns/1ps
module aux_retry_count
  import aux_ctl_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  input  wire logic               ce_in,
  input  wire logic               clear_in,
  input  wire logic               bump_in,
  output logic [RETRY_W-1:0]      count_out,
  output logic                    exhausted_out
);
  typedef struct packed {
    logic [RETRY_W-1:0] count;
  } rc_t;

  rc_t r;
  rc_t next_r;

  always_comb begin
    next_r = r;
    if (clear_in) begin
      next_r.count = '0;
    end else if (bump_in && r.count != RETRY_W'(MAX_TIMEOUTS)) begin
      next_r.count = r.count + RETRY_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign count_out     = r.count;
  // Original attempt plus every retry may time out before giving up
  assign exhausted_out = (r.count == RETRY_W'(MAX_TIMEOUTS));
endmodule

//--- verilog/aux_source_ctl.sv
// Purpose: source-side link state control of the auxiliary channel
// Assumes: all inputs synchronous to clk_in; the sink keeps its own rules
// Notes:   the serial PHY is outside; this block decides turns and outcomes
`timescale 1ns/1ps
module aux_source_ctl
  import aux_ctl_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  input  wire logic             enable_in,
  input  wire logic             hpd_in,
  input  wire logic             req_valid_in,
  input  wire logic [LEN_W-1:0] req_len_in,
  input  wire logic             phy_req_done_in,
  input  wire logic             phy_reply_valid_in,
  input  wire reply_code_t      phy_reply_code_in,
  output logic                  req_ready_out,
  output logic                  req_reject_out,
  output logic                  phy_start_out,
  output logic                  talk_mode_out,
  output logic                  connector_power_out,
  output logic                  channel_avail_out,
  output logic                  hpd_report_out,
  output logic                  hpd_level_out,
  output logic                  outcome_valid_out,
  output outcome_t              outcome_out,
  output logic                  retry_out,
  output src_state_t            state_out
);
  typedef struct packed {
    src_state_t       state;
    logic             sending;
    logic [LEN_W-1:0] len;
    logic             req_ready;
    logic             req_reject;
    logic             phy_start;
    logic             talk;
    logic             power;
    logic             avail;
    logic             hpd_report;
    logic             hpd_level;
    logic             out_valid;
    outcome_t         outcome;
    logic             retry;
  } st_t;

  st_t r;
  st_t next_r;

  logic             tmr_start;
  logic             tmr_stop;
  logic             reply_expired;
  logic             busy_expired;
  logic             rc_clear;
  logic             rc_bump;
  logic             rc_exhausted;
  logic [RETRY_W-1:0] rc_count;

  // Reply window opens on entry to pending
  // Expiry is registered one edge late, so the load is one short of the window
  aux_wait_timer u_reply_tmr (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .ce_in       (ce_in),
    .start_in    (tmr_start),
    .stop_in     (tmr_stop),
    .load_in     (TMR_W'(REPLY_WAIT_CYC - 1)),
    .expired_out (reply_expired)
  );

  // Guards the request phase of one transaction; its expiry is acted on only while sending
  aux_wait_timer u_busy_tmr (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .ce_in       (ce_in),
    .start_in    (r.phy_start),
    .stop_in     (tmr_stop),
    .load_in     (TMR_W'(MAX_TXN_CYC)),
    .expired_out (busy_expired)
  );

  aux_retry_count u_retry (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .ce_in         (ce_in),
    .clear_in      (rc_clear),
    .bump_in       (rc_bump),
    .count_out     (rc_count),
    .exhausted_out (rc_exhausted)
  );

  always_comb begin
    next_r = r;
    tmr_start = 1'b0;
    tmr_stop  = 1'b0;
    rc_clear  = 1'b0;
    rc_bump   = 1'b0;
    next_r.req_reject = 1'b0;
    next_r.phy_start  = 1'b0;
    next_r.hpd_report = 1'b0;
    next_r.out_valid  = 1'b0;
    next_r.retry      = 1'b0;
    unique case (r.state)
      source_reset_state: begin
        if (enable_in) begin
          next_r.state      = source_unplugged_state; // R22
          next_r.hpd_report = 1'b1; // R23
          next_r.hpd_level  = hpd_in; // R23
        end
      end
      source_unplugged_state: begin
        if (hpd_in) begin
          next_r.state = source_idle_state; // R02 R11
        end
      end
      source_idle_state: begin
        if (!hpd_in) begin
          next_r.state      = source_unplugged_state; // R11
          next_r.sending    = 1'b0;
          next_r.hpd_report = 1'b1; // R23
          next_r.hpd_level  = hpd_in;
          tmr_stop          = 1'b1;
          // A stale retry must not fire after the sink comes back
          rc_clear          = 1'b1;
        end else if (r.sending) begin
          // Stays talking until the PHY reports the stop condition
          if (phy_req_done_in) begin
            next_r.state   = source_request_pending_state; // R06
            next_r.sending = 1'b0;
            tmr_start      = 1'b1; // R09
          end else if (busy_expired) begin
            next_r.sending   = 1'b0; // R21
            next_r.out_valid = 1'b1;
            next_r.outcome   = OUT_TIMEOUT;
            // Abort ends the request, so no retry follows
            rc_clear         = 1'b1;
          end
        end else if (!rc_exhausted && rc_count != '0) begin
          // Automatic retry of the last request after a reply timeout
          next_r.sending   = 1'b1; // R24
          next_r.phy_start = 1'b1;
          next_r.retry     = 1'b1;
        end else if (req_valid_in && r.req_ready) begin
          if (req_len_in > LEN_W'(MAX_BYTES)) begin
            next_r.req_reject = 1'b1; // R20
          end else begin
            next_r.len       = req_len_in; // R18
            next_r.sending   = 1'b1; // R01
            next_r.phy_start = 1'b1;
            rc_clear         = 1'b1;
          end
        end
      end
      source_request_pending_state: begin
        if (!hpd_in) begin
          next_r.state      = source_unplugged_state; // R11
          next_r.hpd_report = 1'b1; // R23
          next_r.hpd_level  = hpd_in;
          tmr_stop          = 1'b1;
          rc_clear          = 1'b1;
        end else if (phy_reply_valid_in) begin
          next_r.state     = source_idle_state; // R17
          tmr_stop         = 1'b1;
          rc_clear         = 1'b1;
          next_r.out_valid = 1'b1; // R25
          unique case (phy_reply_code_in)
            REPLY_NACK:  next_r.outcome = OUT_NACK; // R19
            REPLY_DEFER: next_r.outcome = OUT_DEFER; // R19
            default:     next_r.outcome = OUT_ACK;
          endcase
        end else if (reply_expired) begin
          next_r.state = source_idle_state; // R09 R16
          tmr_stop     = 1'b1;
          rc_bump      = 1'b1;
          // Only the timeout of the last retry reaches the policy maker
          if (rc_count == RETRY_W'(MIN_RETRIES)) begin // R24
            next_r.out_valid = 1'b1; // R25
            next_r.outcome   = OUT_TIMEOUT;
          end
        end
      end
    endcase
    if (!enable_in) begin
      next_r.state   = source_reset_state; // R11
      next_r.sending = 1'b0;
      tmr_stop       = 1'b1;
      rc_clear       = 1'b1;
    end
    next_r.talk      = (next_r.state == source_idle_state); // R05 R16
    next_r.power     = (next_r.state != source_reset_state); // R10
    next_r.avail     = (next_r.state == source_idle_state);
    next_r.req_ready = (next_r.state == source_idle_state) && !next_r.sending
                       && (rc_count == '0 || rc_exhausted) && !rc_bump; // R25 R17
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0; // R22
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign req_ready_out       = r.req_ready;
  assign req_reject_out      = r.req_reject;
  assign phy_start_out       = r.phy_start;
  assign talk_mode_out       = r.talk;
  assign connector_power_out = r.power;
  assign channel_avail_out   = r.avail;
  assign hpd_report_out      = r.hpd_report;
  assign hpd_level_out       = r.hpd_level;
  assign outcome_valid_out   = r.out_valid;
  assign outcome_out         = r.outcome;
  assign retry_out           = r.retry;
  assign state_out           = r.state;
endmodule

//--- dv/aux_source_ctl_sva.sv
// Purpose: port-level checks of the auxiliary channel source controller
// Assumes: one clock domain; reset asynchronous, active high
// Notes:   bound onto every aux_source_ctl instance
`timescale 1ns/1ps
module aux_source_ctl_sva
  import aux_ctl_pkg::*;
(
  input wire logic             clk_in,
  input wire logic             sys_rst_in,
  input wire logic             ce_in,
  input wire logic             enable_in,
  input wire logic             hpd_in,
  input wire logic             req_valid_in,
  input wire logic [LEN_W-1:0] req_len_in,
  input wire logic             phy_req_done_in,
  input wire logic             phy_reply_valid_in,
  input wire reply_code_t      phy_reply_code_in,
  input wire logic             req_ready_out,
  input wire logic             phy_start_out,
  input wire logic             talk_mode_out,
  input wire logic             connector_power_out,
  input wire logic             channel_avail_out,
  input wire logic             hpd_report_out,
  input wire logic             hpd_level_out,
  input wire logic             outcome_valid_out,
  input wire outcome_t         outcome_out,
  input wire src_state_t       state_out
);
  logic [TMR_W-1:0] pend_cnt;
  logic             go;
  assign go = ce_in && enable_in && hpd_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // Counts edges spent waiting for a reply so a stuck timer shows up
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_cnt <= '0;
    end else begin
      pend_cnt <= (state_out == source_request_pending_state) ? pend_cnt + 1'b1 : '0;
    end
  end
  power_by_state_a: assert property (
    connector_power_out == (state_out != source_reset_state))
    else $error("connector power does not follow state");
  talk_by_state_a: assert property (
    talk_mode_out == (state_out == source_idle_state) && channel_avail_out == talk_mode_out)
    else $error("talk mode does not follow state");
  take_request_a: assert property (
    state_out == source_idle_state && req_ready_out && req_valid_in && go
    && req_len_in <= MAX_BYTES |=> phy_start_out && !req_ready_out)
    else $error("accepted request did not start");
  done_to_pending_a: assert property (
    state_out == source_idle_state && phy_req_done_in && go
    |=> state_out == source_request_pending_state && !talk_mode_out)
    else $error("request end did not enter reply wait");
  reply_outcome_a: assert property (
    state_out == source_request_pending_state && phy_reply_valid_in && go
    |=> state_out == source_idle_state && outcome_valid_out
    && outcome_out == (($past(phy_reply_code_in) == REPLY_OTHER) ? OUT_ACK
    : outcome_t'($past(phy_reply_code_in))))
    else $error("reply outcome wrong");
  reply_wait_a: assert property (
    state_out == source_request_pending_state |-> pend_cnt < REPLY_WAIT_CYC)
    else $error("reply wait overran");
  hpd_loss_a: assert property (
    (state_out == source_idle_state || state_out == source_request_pending_state)
    && !hpd_in && ce_in && enable_in
    |=> state_out == source_unplugged_state && hpd_report_out && !hpd_level_out)
    else $error("detect loss not handled");
  outcome_pulse_a: assert property (
    outcome_valid_out |=> !outcome_valid_out)
    else $error("outcome event longer than one cycle");
endmodule

bind aux_source_ctl aux_source_ctl_sva u_sva (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in), .enable_in(enable_in),
  .hpd_in(hpd_in), .req_valid_in(req_valid_in), .req_len_in(req_len_in),
  .phy_req_done_in(phy_req_done_in), .phy_reply_valid_in(phy_reply_valid_in),
  .phy_reply_code_in(phy_reply_code_in), .req_ready_out(req_ready_out),
  .phy_start_out(phy_start_out), .talk_mode_out(talk_mode_out),
  .connector_power_out(connector_power_out), .channel_avail_out(channel_avail_out),
  .hpd_report_out(hpd_report_out), .hpd_level_out(hpd_level_out),
  .outcome_valid_out(outcome_valid_out), .outcome_out(outcome_out), .state_out(state_out));

//--- dv/aux_sink_model.sv
// Purpose: behavioural far side: request framing end and sink replier
// Assumes: mode 0 replies, 1 sink gives up silently, 2 request never ends
// Notes:   all outputs change on the falling edge
`timescale 1ns/1ps
module aux_sink_model
  import aux_ctl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        start_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic [7:0]  done_dly_in,
  input  wire logic [7:0]  reply_dly_in,
  input  wire reply_code_t code_in,
  output logic             done_out,
  output logic             reply_valid_out,
  output reply_code_t      reply_code_out
);
  logic [1:0]  idle_pat;
  reply_code_t held;
  // Code lines wander outside a reply so a stale code can never pass
  assign reply_code_out = reply_valid_out ? held : reply_code_t'(idle_pat);
  always @(negedge clk_in) begin
    idle_pat <= idle_pat + 2'h1;
  end
  initial begin
    done_out = 1'b0;
    reply_valid_out = 1'b0;
    held = REPLY_ACK;
    idle_pat = 2'h0;
    forever begin
      @(negedge clk_in);
      // Listens in idle and answers only a request from the source
      if (start_in === 1'b1 && sys_rst_in === 1'b0 && mode_in != 2'h2) begin
        repeat (done_dly_in + 1) @(negedge clk_in);
        done_out = 1'b1;
        @(negedge clk_in);
        done_out = 1'b0;
        // Reply well inside the response window, or give up without a word
        if (mode_in == 2'h0) begin
          repeat (reply_dly_in + 1) @(negedge clk_in);
          held = code_in;
          reply_valid_out = 1'b1;
          @(negedge clk_in);
          reply_valid_out = 1'b0;
        end
      end
    end
  end
endmodule

//--- dv/tb_aux_channel_link_state_control.sv
// Purpose: self-checking bench for the auxiliary channel source controller
// Assumes: ce_in held high; sink model set per test
// Notes:   the fixed reply and talk timeouts dominate run time
`timescale 1ns/1ps
module tb_aux_channel_link_state_control
  import aux_ctl_pkg::*;
;
  logic             clk_in, sys_rst_in, enable, hpd, req_valid, done, rvalid;
  logic             ready, reject, start, talk, power, avail, report, level, oval, retry;
  logic [LEN_W-1:0] req_len;
  logic [1:0]       mode;
  logic [7:0]       done_dly, reply_dly;
  reply_code_t      code, rcode;
  outcome_t         outcome;
  src_state_t       state;
  int               err_count, comparisons, cycles, st, rt, n;

  aux_source_ctl u_dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1), .enable_in(enable),
    .hpd_in(hpd), .req_valid_in(req_valid), .req_len_in(req_len), .phy_req_done_in(done),
    .phy_reply_valid_in(rvalid), .phy_reply_code_in(rcode), .req_ready_out(ready),
    .req_reject_out(reject), .phy_start_out(start), .talk_mode_out(talk),
    .connector_power_out(power), .channel_avail_out(avail), .hpd_report_out(report),
    .hpd_level_out(level), .outcome_valid_out(oval), .outcome_out(outcome),
    .retry_out(retry), .state_out(state));
  aux_sink_model u_sink (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start), .mode_in(mode),
    .done_dly_in(done_dly), .reply_dly_in(reply_dly), .code_in(code), .done_out(done),
    .reply_valid_out(rvalid), .reply_code_out(rcode));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      err_count++;
      complete_run();
    end
  end

  function automatic logic [1:0] exp_out(input reply_code_t c);
    return (c == REPLY_OTHER) ? 2'h0 : 2'(c);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Request held from a falling edge until the rising edge that takes it
  task automatic put_req(input logic [LEN_W-1:0] len, input logic [1:0] md);
    @(negedge clk_in);
    mode = md;
    req_valid = 1'b1;
    req_len = len;
    while (ready !== 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    req_valid = 1'b0;
  endtask
  task automatic txn(input logic [LEN_W-1:0] len, input logic [1:0] md);
    put_req(len, md);
    st = 0;
    rt = 0;
    n = 0;
    while (oval !== 1'b1 && n < 70000) begin
      st += (start === 1'b1);
      rt += (retry === 1'b1);
      @(negedge clk_in);
      n++;
    end
    check(oval, 1'b1);
  endtask

  initial begin
    err_count = 0;
    comparisons = 0;
    cycles = 0;
    sys_rst_in = 1'b1;
    enable = 1'b1;
    hpd = 1'b0;
    req_valid = 1'b0;
    req_len = '0;
    mode = 2'h0;
    done_dly = 8'h01;
    reply_dly = 8'h01;
    code = REPLY_ACK;
    void'($urandom(22));
    repeat (2) @(negedge clk_in);
    check({state, power}, {source_reset_state, 1'b0});
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    check({state, power, report, level}, {source_unplugged_state, 3'h6});
    hpd = 1'b1;
    @(negedge clk_in);
    check({state, talk, avail}, {source_idle_state, 2'h3});
    $display("test plug-in done");
    for (int i = 0; i < 12; i++) begin
      code = reply_code_t'($urandom_range(3, 0));
      done_dly = 8'($urandom_range(30, 0));
      reply_dly = 8'($urandom_range(60, 0));
      txn((i < 2) ? 5'(i * MAX_BYTES) : 5'($urandom_range(MAX_BYTES, 0)), 2'h0);
      check(outcome, exp_out(code));
      check(st, 1);
    end
    put_req(5'($urandom_range(31, 17)), 2'h0);
    check({reject, start}, 2'h2);
    $display("test exchanges and length limit done");
    txn(5'h04, 2'h1);
    check({outcome, st[3:0], rt[3:0]}, {OUT_TIMEOUT, 4'h4, 4'h3});
    txn(5'h08, 2'h2);
    check({outcome, st[3:0]}, {OUT_TIMEOUT, 4'h1});
    $display("test timeouts done");
    put_req(5'h02, 2'h1);
    n = 0;
    while (state !== source_request_pending_state && n < 100) begin
      @(negedge clk_in);
      n++;
    end
    check(state, source_request_pending_state);
    hpd = 1'b0;
    @(negedge clk_in);
    check({state, power, report, level}, {source_unplugged_state, 3'h6});
    hpd = 1'b1;
    @(negedge clk_in);
    check({state, talk}, {source_idle_state, 1'b1});
    enable = 1'b0;
    @(negedge clk_in);
    check({state, power}, {source_reset_state, 1'b0});
    enable = 1'b1;
    @(negedge clk_in);
    check({state, report, level}, {source_unplugged_state, 2'h3});
    @(negedge clk_in);
    check(state, source_idle_state);
    $display("test detect loss and disable done");
    complete_run();
  end
endmodule
